// ---- apsc_pkg.sv ----
package apsc_pkg;
   // power modes
   typedef enum logic [1:0] {
      APSC_PWR_LOW = 2'b00,
      APSC_PWR_HALF = 2'b01,
      APSC_PWR_FULL = 2'b10
   } apsc_power_type;

   // sequencer states of the serial control port
   typedef enum logic [1:0] {
      APSC_SP_BLOCKED = 2'b00,
      APSC_SP_IDLE = 2'b01,
      APSC_SP_SHIFT = 2'b10
   } apsc_spi_state_type;

   localparam int unsigned APSC_CHANNELS = 8;
   localparam int unsigned APSC_BANK = 4;
   localparam int unsigned APSC_HDR_BITS = 8;
   localparam int unsigned APSC_RES_BITS = 16;
   localparam int unsigned APSC_WORD_BITS = 24;
   localparam int unsigned APSC_FRAME_BITS = 16;
   localparam int unsigned APSC_RW_BIT = 15;
   localparam int unsigned APSC_ADDR_HI = 14;
   localparam int unsigned APSC_ADDR_LO = 8;
   localparam int unsigned APSC_HDR_ERR_BIT = 7;
   localparam int unsigned APSC_HDR_UNSETTLED_BIT = 6;
   localparam int unsigned APSC_HDR_FILTER_BIT = 5;
   localparam int unsigned APSC_HDR_SAT_BIT = 4;
   localparam logic [3:0] APSC_ONESHOT_FIRST = 4'h0_00C;
   localparam logic [3:0] APSC_CODE_C = 4'h0_00C;
   localparam logic [3:0] APSC_CODE_D = 4'h0_00D;
   localparam logic [3:0] APSC_CODE_E = 4'h0_00E;
   localparam logic [5:0] APSC_MOD_DIV_FULL = 6'h0_004;
   localparam logic [5:0] APSC_MOD_DIV_HALF = 6'h0_008;
   localparam logic [5:0] APSC_MOD_DIV_LOW = 6'h0_020;
   localparam logic [1:0] APSC_DATA_SHIFT_CLOCK_DIV1 = 2'h0_000;
   localparam logic [1:0] APSC_DATA_SHIFT_CLOCK_DIV2 = 2'h0_001;
   localparam logic [10:0] APSC_DEC_32 = 11'h0_020;
   localparam logic [10:0] APSC_DEC_64 = 11'h0_040;
   localparam logic [10:0] APSC_DEC_128 = 11'h0_080;
   localparam logic [10:0] APSC_DEC_1024 = 11'h0_400;
   // start-up time that blocks serial access after reset
   localparam int unsigned APSC_STARTUP_US = 100;
   localparam int unsigned APSC_CLK_MHZ = 100;
   localparam int unsigned APSC_STARTUP_CYC = APSC_STARTUP_US * APSC_CLK_MHZ;
   localparam logic [15:0] APSC_ZERO16 = 16'h0000;
endpackage : apsc_pkg

// ---- apsc_spi_shifter.sv ----
`timescale 1ns/10ps
// 16-bit mode-0 shifter, sampled on the system clock
module apsc_spi_shifter #(
   parameter int unsigned BITS = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic sclkRise,
   input wire logic sclkFall,
   input wire logic csFall,
   input wire logic csActive,
   input wire logic sdi,
   input wire logic [BITS-1:0] txWord,
   output logic sdo,
   output logic [BITS-1:0] rxWord,
   output logic rxDone
);
   logic [BITS-1:0] shiftIn_r;
   logic [BITS-1:0] shiftOut_r;
   logic [$clog2(BITS+1)-1:0] count_r;

   // =========================================================
   // receive: capture on rising sclk
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shiftIn_r <= '0;
         count_r <= '0;
         rxDone <= 1'b0;
         rxWord <= '0;
      end
      else
      begin
         rxDone <= 1'b0;
         if (csFall || !csActive)
            count_r <= '0;
         else if (enable && sclkRise)
         begin
            shiftIn_r <= {shiftIn_r[BITS-2:0], sdi};
            if (count_r == ($clog2(BITS+1))'(BITS - 1))
            begin
               rxWord <= {shiftIn_r[BITS-2:0], sdi};
               rxDone <= 1'b1;
               count_r <= '0;
            end
            else
               count_r <= count_r + 1'b1;
         end
      end
   end

   // =========================================================
   // transmit: msb presented at cs fall, next bits on falling sclk
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shiftOut_r <= '0;
         sdo <= 1'b0;
      end
      else if (csFall)
      begin
         shiftOut_r <= {txWord[BITS-2:0], 1'b0};
         sdo <= txWord[BITS-1];
      end
      else if (csActive && sclkFall)
      begin
         sdo <= shiftOut_r[BITS-1];
         shiftOut_r <= {shiftOut_r[BITS-2:0], 1'b0};
      end
   end
endmodule : apsc_spi_shifter

// ---- apsc_strap_config.sv ----
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
// What this block does
// - four straps decode sixteen common settings
// - codes 0-B standard, power, clock divider
// - codes C-F one-shot fixed settings
// - power mode sets modulator clock division
// - modulator clock divides 4, 8, 32
// - errors reported in every non-standby channel header
// - error sources set header bit seven
// - header carries unsettled, filter, saturation flags
// - channel word is header plus result
// - bank straps place channel groups in standby
// - standby channels output zero words
// - channel 0 standby disables common mode
// - channel 4 standby disables crystal drive
// - serial port uses spi mode zero
// - select pin high enables 16-bit port
// - serial port independent of conversion clocks
// - serial access ignored during start-up
// - filter strap selects sinc5 or wideband
// - decimation straps select 32,64,128,1024
// - frame has read flag and address
module apsc_strap_config #(
   parameter int unsigned STARTUP_CYCLES = apsc_pkg::APSC_STARTUP_CYC,
   parameter int unsigned CHANNELS = apsc_pkg::APSC_CHANNELS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] operatingCodeStraps,
   input wire logic lowBankStandbyStrap,
   input wire logic highBankStandbyStrap,
   input wire logic filterStrap,
   input wire logic [1:0] decimationStraps,
   input wire logic syncPulse,
   input wire logic ctrlSourceSelect,
   input wire logic checksumError,
   input wire logic memoryFlipError,
   input wire logic clockMissing,
   input wire logic [CHANNELS-1:0] filterUnsettled,
   input wire logic [CHANNELS-1:0] filterSaturated,
   input wire logic [CHANNELS*16-1:0] convResults,
   input wire logic frameStart,
   input wire logic spiClk,
   input wire logic spiCs_n,
   input wire logic spiDataIn,
   input wire logic [15:0] spiReadData,
   output logic spiDataOut,
   output logic spiDataOutEn,
   output logic spiCmdValid,
   output logic spiCmdRead,
   output logic [6:0] spiCmdAddr,
   output logic [7:0] spiCmdData,
   output logic [1:0] powerMode,
   output logic oneShot,
   output logic [5:0] modulatorDivide,
   output logic [3:0] dataClockDivider,
   output logic modulatorClockEn,
   output logic dataShiftClockEn,
   output logic sinc5Selected,
   output logic [10:0] decimationRatio,
   output logic [CHANNELS-1:0] channelStandby,
   output logic commonModeEnable,
   output logic crystalEnable,
   output logic [CHANNELS*24-1:0] channelWords
);
   // =========================================================
   // two-flop synchronisers for all pin inputs
   logic [13:0] pinMeta_r;
   logic [13:0] pinSync_r;
   logic [13:0] pinRaw;
   assign pinRaw = {operatingCodeStraps, lowBankStandbyStrap, highBankStandbyStrap,
                    filterStrap, decimationStraps, syncPulse, ctrlSourceSelect,
                    spiClk, spiCs_n, spiDataIn};
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pinMeta_r <= 14'h0_002; // idle pins: cs_n high, select and all else low
         pinSync_r <= 14'h0_002;
      end
      else
      begin
         pinMeta_r <= pinRaw;
         pinSync_r <= pinMeta_r;
      end
   end
   logic [3:0] codeS;
   logic st0S;
   logic st1S;
   logic filterS;
   logic [1:0] decS;
   logic syncS;
   logic selS;
   logic sclkS;
   logic csnS;
   logic sdiS;
   assign {codeS, st0S, st1S, filterS, decS, syncS, selS, sclkS, csnS, sdiS} = pinSync_r;

   // =========================================================
   // strap decode: power in [4:3], data_shift_clock in [2:1], one-shot in [0]
   function automatic logic [4:0] decodeCode(input logic [3:0] code);
      logic [4:0] r;
      r = {code[3:2], code[1:0], 1'b0};
      if (code >= apsc_pkg::APSC_ONESHOT_FIRST)
      begin
         case (code)
            apsc_pkg::APSC_CODE_C: r = {apsc_pkg::APSC_PWR_LOW, apsc_pkg::APSC_DATA_SHIFT_CLOCK_DIV1, 1'b1};
            apsc_pkg::APSC_CODE_D: r = {apsc_pkg::APSC_PWR_HALF, apsc_pkg::APSC_DATA_SHIFT_CLOCK_DIV1, 1'b1};
            apsc_pkg::APSC_CODE_E: r = {apsc_pkg::APSC_PWR_FULL, apsc_pkg::APSC_DATA_SHIFT_CLOCK_DIV2, 1'b1};
            default: r = {apsc_pkg::APSC_PWR_FULL, apsc_pkg::APSC_DATA_SHIFT_CLOCK_DIV1, 1'b1};
         endcase
      end
      return r;
   endfunction : decodeCode

   function automatic logic [5:0] modDiv(input logic [1:0] pm);
      case (pm)
         apsc_pkg::APSC_PWR_FULL: modDiv = apsc_pkg::APSC_MOD_DIV_FULL;
         apsc_pkg::APSC_PWR_HALF: modDiv = apsc_pkg::APSC_MOD_DIV_HALF;
         default: modDiv = apsc_pkg::APSC_MOD_DIV_LOW;
      endcase
   endfunction : modDiv

   function automatic logic [10:0] decRatio(input logic [1:0] d);
      case (d)
         2'h0: decRatio = apsc_pkg::APSC_DEC_32;
         2'h1: decRatio = apsc_pkg::APSC_DEC_64;
         2'h2: decRatio = apsc_pkg::APSC_DEC_128;
         default: decRatio = apsc_pkg::APSC_DEC_1024;
      endcase
   endfunction : decRatio

   // =========================================================
   // latch straps, while select is low, once the synchronisers hold real pin values after reset, and at each sync rise
   logic syncDly_r;
   logic [2:0] settle_r;
   logic loadNow;
   logic [4:0] decoded;
   assign decoded = decodeCode(codeS);
   assign loadNow = (settle_r == 3'b011) || (syncS && !syncDly_r);
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         syncDly_r <= 1'b0;
         settle_r <= '0;
         powerMode <= apsc_pkg::APSC_PWR_LOW;
         oneShot <= 1'b0;
         modulatorDivide <= apsc_pkg::APSC_MOD_DIV_LOW;
         dataClockDivider <= 4'h0_001;
         sinc5Selected <= 1'b1;
         decimationRatio <= apsc_pkg::APSC_DEC_1024;
         channelStandby <= '0;
      end
      else
      begin
         syncDly_r <= syncS;
         settle_r <= {settle_r[1:0], 1'b1};
         if (loadNow && !selS)
         begin
            powerMode <= decoded[4:3];
            oneShot <= decoded[0];
            modulatorDivide <= modDiv(decoded[4:3]);
            dataClockDivider <= 4'(4'h0_001 << decoded[2:1]);
            sinc5Selected <= filterS;
            decimationRatio <= decRatio(decS);
            channelStandby <= {{apsc_pkg::APSC_BANK{st1S}}, {apsc_pkg::APSC_BANK{st0S}}};
         end
      end
   end
   assign commonModeEnable = !channelStandby[0];
   assign crystalEnable = !channelStandby[4];

   // =========================================================
   // clock enables: data clock divider ratio only changes at a frame boundary, modulator ratio at once
   logic [5:0] modCnt_r;
   logic [3:0] dclkCnt_r;
   logic [3:0] dclkDivHeld_r;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         modCnt_r <= '0;
         modulatorClockEn <= 1'b0;
      end
      else if (modCnt_r >= modulatorDivide - 6'h0_001)
      begin
         modCnt_r <= '0;
         modulatorClockEn <= 1'b1;
      end
      else
      begin
         modCnt_r <= modCnt_r + 6'h0_001;
         modulatorClockEn <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dclkCnt_r <= '0;
         dclkDivHeld_r <= 4'h0_001;
         dataShiftClockEn <= 1'b0;
      end
      else
      begin
         if (frameStart)
            dclkDivHeld_r <= dataClockDivider;
         if (dclkCnt_r >= dclkDivHeld_r - 4'h0_001)
         begin
            dclkCnt_r <= '0;
            dataShiftClockEn <= 1'b1;
         end
         else
         begin
            dclkCnt_r <= dclkCnt_r + 4'h0_001;
            dataShiftClockEn <= 1'b0;
         end
      end
   end

   // =========================================================
   // per-channel 24-bit words: header then result, zero in standby
   logic globalError;
   assign globalError = checksumError || memoryFlipError || clockMissing;
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_word
         logic [7:0] header;
         always_comb
         begin
            header = '0;
            header[apsc_pkg::APSC_HDR_ERR_BIT] = globalError;
            header[apsc_pkg::APSC_HDR_UNSETTLED_BIT] = filterUnsettled[ch];
            header[apsc_pkg::APSC_HDR_FILTER_BIT] = sinc5Selected;
            header[apsc_pkg::APSC_HDR_SAT_BIT] = filterSaturated[ch];
         end
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               channelWords[ch*24 +: 24] <= '0;
            else if (channelStandby[ch])
               channelWords[ch*24 +: 24] <= '0;
            else
               channelWords[ch*24 +: 24] <= {header, convResults[ch*16 +: 16]};
         end
      end
   endgenerate

   // =========================================================
   // serial control port, runs only from sampled pins, not the data clocks
   logic sclkDly_r;
   logic csnDly_r;
   logic [$clog2(STARTUP_CYCLES+1)-1:0] startCnt_r;
   logic spiReady;
   logic [15:0] rxWord;
   logic rxDone;
   logic [15:0] respWord_r;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclkDly_r <= 1'b0;
         csnDly_r <= 1'b1;
         startCnt_r <= '0;
      end
      else
      begin
         sclkDly_r <= sclkS;
         csnDly_r <= csnS;
         if (!spiReady)
            startCnt_r <= startCnt_r + 1'b1;
      end
   end
   assign spiReady = (startCnt_r == ($clog2(STARTUP_CYCLES+1))'(STARTUP_CYCLES));

   apsc_spi_shifter #(
      .BITS(apsc_pkg::APSC_FRAME_BITS)
   ) u_shift (
      .clk(clk),
      .arst_n(arst_n),
      .enable(spiReady && selS),
      .sclkRise(sclkS && !sclkDly_r),
      .sclkFall(!sclkS && sclkDly_r),
      .csFall(!csnS && csnDly_r),
      .csActive(!csnS),
      .sdi(sdiS),
      .txWord(respWord_r),
      .sdo(spiDataOut),
      .rxWord(rxWord),
      .rxDone(rxDone)
   );
   assign spiDataOutEn = !csnS && selS;

   // decoded command pulse; response goes out in the next frame
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         spiCmdValid <= 1'b0;
         spiCmdRead <= 1'b0;
         spiCmdAddr <= '0;
         spiCmdData <= '0;
         respWord_r <= apsc_pkg::APSC_ZERO16;
      end
      else
      begin
         spiCmdValid <= rxDone;
         if (rxDone)
         begin
            spiCmdRead <= rxWord[apsc_pkg::APSC_RW_BIT];
            spiCmdAddr <= rxWord[apsc_pkg::APSC_ADDR_HI:apsc_pkg::APSC_ADDR_LO];
            spiCmdData <= rxWord[7:0];
         end
         if (spiCmdValid)
            respWord_r <= spiCmdRead ? spiReadData : apsc_pkg::APSC_ZERO16;
      end
   end
endmodule : apsc_strap_config

// ---- apsc_strap_config_asserts.sv ----
`timescale 1ns/10ps
// ==========================================
// checker on the strap decoder ports
module apsc_strap_config_asserts #(
   parameter int unsigned STARTUP_CYCLES = 20,
   parameter int unsigned CHANNELS = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic syncPulse,
   input wire logic ctrlSourceSelect,
   input wire logic checksumError,
   input wire logic memoryFlipError,
   input wire logic clockMissing,
   input wire logic frameStart,
   input wire logic spiCs_n,
   input wire logic spiCmdValid,
   input wire logic spiDataOutEn,
   input wire logic [1:0] powerMode,
   input wire logic [5:0] modulatorDivide,
   input wire logic [3:0] dataClockDivider,
   input wire logic modulatorClockEn,
   input wire logic dataShiftClockEn,
   input wire logic [CHANNELS-1:0] channelStandby,
   input wire logic commonModeEnable,
   input wire logic crystalEnable,
   input wire logic [CHANNELS*24-1:0] channelWords
);
   logic [15:0] upCnt;
   logic [5:0] modGap;
   logic [3:0] dclkGap;
   logic [3:0] heldDiv;
   logic errAny;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   assign errAny = checksumError | memoryFlipError | clockMissing;
   // cycles since reset release, saturating
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         upCnt <= 16'h0000;
      else if (upCnt != 16'hFFFF)
         upCnt <= upCnt + 16'h0001;
   end
   // a ratio change restarts the gap count, but an enable seen in the cycle the change is seen has its old period checked against the new ratio
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         modGap <= 6'h00;
      else if ($changed(modulatorDivide))
         modGap <= 6'h00;
      else if (modulatorClockEn)
         modGap <= 6'h01;
      else if (modGap != 6'h00 && modGap != 6'h3F)
         modGap <= modGap + 6'h01;
   end
   // the ratio in force is the one taken at the last frame start, which restarts the gap
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         heldDiv <= 4'h1;
      else if (frameStart)
         heldDiv <= dataClockDivider;
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         dclkGap <= 4'h0;
      else if (frameStart)
         dclkGap <= 4'h0;
      else if (dataShiftClockEn)
         dclkGap <= 4'h1;
      else if (dclkGap != 4'h0 && dclkGap != 4'hF)
         dclkGap <= dclkGap + 4'h1;
   end
   sequence csHigh;
      spiCs_n [*3];
   endsequence
   sequence errHeld;
      (errAny && !channelStandby[0]) [*3];
   endsequence
   // ==========================================
   // assertions
   AST_CM_FOLLOWS_CH0: assert property (commonModeEnable == !channelStandby[0])
      else $error("common mode enable disagrees with channel 0 standby");
   AST_XTAL_FOLLOWS_CH4: assert property (crystalEnable == !channelStandby[4])
      else $error("crystal enable disagrees with channel 4 standby");
   AST_BANK_GROUPS: assert property (channelStandby[3:0] inside {4'h0, 4'hF} &&
      channelStandby[7:4] inside {4'h0, 4'hF}) else $error("standby not in banks of four");
   AST_CH0_ZERO: assert property (channelStandby[0] [*2] |-> channelWords[23:0] == 24'h00_0000)
      else $error("standby channel 0 word not zero");
   AST_LAST_ZERO: assert property (channelStandby[CHANNELS-1] [*2] |->
      channelWords[CHANNELS*24-1 -: 24] == 24'h00_0000) else $error("standby last word not zero");
   AST_ERR_HEADER: assert property (errHeld |-> channelWords[23])
      else $error("error bit missing in header");
   AST_MOD_RATIO: assert property (modulatorDivide == ((powerMode == 2'h2) ? 6'h04 :
      (powerMode == 2'h1) ? 6'h08 : 6'h20)) else $error("modulator ratio wrong for power mode");
   AST_MOD_PERIOD: assert property (modulatorClockEn && modGap != 6'h00 |->
      modGap == modulatorDivide) else $error("modulator enable period wrong");
   AST_DATA_SHIFT_CLOCK_PERIOD: assert property (dataShiftClockEn && dclkGap != 4'h0 |->
      dclkGap == heldDiv) else $error("data clock enable period wrong");
   AST_CFG_HOLD: assert property ($changed(powerMode) || $changed(channelStandby) |->
      upCnt < 16'h0008 || $past(syncPulse, 2) || $past(syncPulse, 3) || $past(syncPulse, 4)
      || $past(syncPulse, 5)) else $error("configuration moved without sync");
   AST_SPI_STARTUP: assert property (spiCmdValid |-> upCnt >= STARTUP_CYCLES)
      else $error("serial command taken during start-up");
   AST_SPI_SELECT: assert property (spiCmdValid |-> $past(ctrlSourceSelect, 4))
      else $error("serial command taken while deselected");
   AST_SDO_IDLE: assert property (csHigh |-> !spiDataOutEn)
      else $error("serial output driven outside frame");
endmodule : apsc_strap_config_asserts
bind apsc_strap_config apsc_strap_config_asserts #(
   .STARTUP_CYCLES(STARTUP_CYCLES),
   .CHANNELS(CHANNELS)
) apsc_strap_config_asserts_inst (.clk, .arst_n, .syncPulse, .ctrlSourceSelect, .checksumError,
   .memoryFlipError, .clockMissing, .frameStart, .spiCs_n, .spiCmdValid, .spiDataOutEn,
   .powerMode, .modulatorDivide, .dataClockDivider, .modulatorClockEn, .dataShiftClockEn,
   .channelStandby, .commonModeEnable, .crystalEnable, .channelWords);

// ---- apsc_host_model.sv ----
`timescale 1ns/10ps
// ==========================================
// serial control host, mode 0, clock at clk/12
module apsc_host_model #(
   parameter int HALF = 6,
   parameter int GAP = 8
) (
   input wire logic clk,
   output logic spiClk,
   output logic spiCs_n,
   output logic spiDataIn,
   input wire logic spiDataOut
);
   // idle: clock low, select high
   initial
   begin
      spiClk = 1'b0;
      spiCs_n = 1'b1;
      spiDataIn = 1'b0;
   end
   // one 16-bit frame msb first, answer taken on rising clock
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
      @(posedge clk);
      spiCs_n <= 1'b0;
      spiDataIn <= cmd[15];
      for (int i = 15; i >= 0; i--)
      begin
         repeat (HALF) @(posedge clk);
         spiClk <= 1'b1;
         rsp[i] = spiDataOut;
         repeat (HALF) @(posedge clk);
         spiClk <= 1'b0;
         if (i > 0)
            spiDataIn <= cmd[i-1];
      end
      repeat (HALF) @(posedge clk);
      spiCs_n <= 1'b1;
      // released line shows the opposite level, not a stale bit
      spiDataIn <= ~cmd[0];
      repeat (GAP) @(posedge clk);
   endtask : xfer
endmodule : apsc_host_model

// ---- apsc_strap_config_tb.sv ----
`timescale 1ns/10ps
// ==========================================
// bench for the strap decoder
module apsc_strap_config_tb;
   localparam int STARTUP = 400;
   logic clk, arst_n, lowBankStandbyStrap, highBankStandbyStrap, filterStrap, syncPulse;
   logic ctrlSourceSelect, checksumError, memoryFlipError, clockMissing, frameStart;
   logic spiClk, spiCs_n, spiDataIn, spiDataOut, spiDataOutEn, spiCmdValid, spiCmdRead;
   logic oneShot, modulatorClockEn, dataShiftClockEn, sinc5Selected;
   logic commonModeEnable, crystalEnable;
   logic [3:0] operatingCodeStraps, dataClockDivider;
   logic [1:0] decimationStraps, powerMode;
   logic [7:0] filterUnsettled, filterSaturated, spiCmdData, channelStandby;
   logic [127:0] convResults;
   logic [15:0] spiReadData, cmd, rsp;
   logic [6:0] spiCmdAddr;
   logic [5:0] modulatorDivide;
   logic [10:0] decimationRatio;
   logic [191:0] channelWords, w;
   logic [31:0] r;
   int seed, mismatches, checks_done, validCnt, cycles;
   apsc_strap_config #(.STARTUP_CYCLES(STARTUP)) apsc_strap_config_inst (.clk, .arst_n,
      .operatingCodeStraps, .lowBankStandbyStrap, .highBankStandbyStrap, .filterStrap,
      .decimationStraps, .syncPulse, .ctrlSourceSelect, .checksumError, .memoryFlipError,
      .clockMissing, .filterUnsettled, .filterSaturated, .convResults, .frameStart, .spiClk,
      .spiCs_n, .spiDataIn, .spiReadData, .spiDataOut, .spiDataOutEn, .spiCmdValid,
      .spiCmdRead, .spiCmdAddr, .spiCmdData, .powerMode, .oneShot, .modulatorDivide,
      .dataClockDivider, .modulatorClockEn, .dataShiftClockEn, .sinc5Selected,
      .decimationRatio, .channelStandby, .commonModeEnable, .crystalEnable, .channelWords);
   apsc_host_model apsc_host_model_inst (.clk, .spiClk, .spiCs_n, .spiDataIn, .spiDataOut);
   // ==========================================
   // helpers
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task end_of_test;
      $display("mismatches=%0d checks=%0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test
   task cmpv(input logic [191:0] got, input logic [191:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmpv
   // power, one-shot, modulator ratio and data clock ratio per code
   function automatic logic [12:0] expCfg(input logic [3:0] c);
      logic [1:0] p;
      logic [3:0] d;
      p = (c < 4'hC) ? c[3:2] : (c == 4'hC) ? 2'h0 : (c == 4'hD) ? 2'h1 : 2'h2;
      d = (c < 4'hC) ? 4'h1 << c[1:0] : (c == 4'hE) ? 4'h2 : 4'h1;
      return {p, c >= 4'hC, (p == 2'h2) ? 6'h04 : (p == 2'h1) ? 6'h08 : 6'h20, d};
   endfunction : expCfg
   function automatic logic [10:0] expDec(input logic [1:0] d);
      return (d == 2'h0) ? 11'h020 : (d == 2'h1) ? 11'h040 : (d == 2'h2) ? 11'h080 : 11'h400;
   endfunction : expDec
   // command counter and hang limit; the limit is well above the run length
   always @(posedge clk)
   begin
      if (spiCmdValid === 1'b1)
         validCnt <= validCnt + 1;
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   // ==========================================
   // main sequence
   initial
   begin
      seed = 10586;
      {mismatches, checks_done, validCnt, cycles} = '0;
      arst_n = 1'b0;
      {operatingCodeStraps, lowBankStandbyStrap, highBankStandbyStrap, filterStrap} = '0;
      {decimationStraps, syncPulse, ctrlSourceSelect, frameStart, convResults} = '0;
      {checksumError, memoryFlipError, clockMissing, filterUnsettled, filterSaturated} = '0;
      spiReadData = 16'($random(seed));
      wt(5);
      arst_n <= 1'b1;
      ctrlSourceSelect <= 1'b1;
      // a frame inside start-up is dropped
      apsc_host_model_inst.xfer(16'h1234, rsp);
      cmpv(validCnt, 0);
      wt(STARTUP);
      // write, read, write; the read answer rides on the next frame
      for (int k = 0; k < 3; k++)
      begin
         cmd = 16'($random(seed));
         cmd[15] = (k == 1);
         apsc_host_model_inst.xfer(cmd, rsp);
         wt(4);
         cmpv({validCnt[7:0], spiCmdRead, spiCmdAddr, spiCmdData}, {8'(k + 1), cmd});
         if (k == 2)
            cmpv(rsp, spiReadData);
      end
      ctrlSourceSelect <= 1'b0;
      wt(4);
      apsc_host_model_inst.xfer(16'h8123, rsp);
      wt(4);
      cmpv(validCnt, 3);
      // every code, random banks and filter; no standby and full standby as corners
      for (int i = 0; i < 16; i++)
      begin
         r = $random(seed);
         if (i == 0)
            r[4:3] = 2'h0;
         if (i == 15)
            r[4:3] = 2'h3;
         // full speed at divide-by-8 needs decimation of 64 or more to fit a word per period
         if (i == 11 && r[1:0] == 2'h0)
            r[0] = 1'b1;
         operatingCodeStraps <= 4'(i);
         {highBankStandbyStrap, lowBankStandbyStrap, filterStrap, decimationStraps} <= r[4:0];
         wt(4);
         syncPulse <= 1'b1;
         wt(2);
         syncPulse <= 1'b0;
         wt(4);
         frameStart <= 1'b1;
         wt(1);
         frameStart <= 1'b0;
         for (int j = 0; j < 2; j++)
         begin
            wt(6);
            cmpv({powerMode, oneShot, modulatorDivide, dataClockDivider}, expCfg(4'(i)));
            cmpv({sinc5Selected, decimationRatio, channelStandby, commonModeEnable, crystalEnable},
               {r[2], expDec(r[1:0]), {4{r[4]}}, {4{r[3]}}, ~r[3], ~r[4]});
            // straps move without a sync and must not take effect
            {operatingCodeStraps, highBankStandbyStrap, lowBankStandbyStrap, filterStrap,
               decimationStraps} <= 9'($random(seed));
            {checksumError, memoryFlipError, clockMissing, filterUnsettled,
               filterSaturated} <= 19'($random(seed));
            convResults <= {4{$random(seed)}};
         end
         wt(4);
         for (int n = 0; n < 8; n++)
            w[n*24 +: 24] = (n < 4 ? r[3] : r[4]) ? 24'h00_0000 : {checksumError | memoryFlipError
               | clockMissing, filterUnsettled[n], r[2], filterSaturated[n], 4'h0,
               convResults[n*16 +: 16]};
         cmpv(channelWords, w);
      end
      // mid-run reset: defaults while held, then straps taken once after release
      arst_n <= 1'b0;
      {operatingCodeStraps, highBankStandbyStrap, lowBankStandbyStrap, filterStrap,
         decimationStraps} <= 9'h12A;
      wt(2);
      cmpv({powerMode, oneShot, modulatorDivide, dataClockDivider}, expCfg(4'h0));
      cmpv({sinc5Selected, decimationRatio, channelStandby}, {1'b1, expDec(2'h3), 8'h00});
      cmpv(channelWords, '0);
      arst_n <= 1'b1;
      wt(8);
      cmpv({powerMode, oneShot, modulatorDivide, dataClockDivider}, expCfg(4'h9));
      cmpv({sinc5Selected, decimationRatio, channelStandby}, {1'b0, expDec(2'h2), 8'h0F});
      end_of_test();
   end
endmodule : apsc_strap_config_tb
